// ==== logic/mbi_bus_if.sv ====
// multiplexed address/data bus sequencer with request queue
// Overview of operation
// - one 16-bit bus carries address then data for every memory and I/O transfer
// - high level is 1; line 0 least, line 15 most significant
// - address strobe low while address is out, stable at its rise
// - status outputs mark memory or I/O address during address phase
// - data strobe low only while bus transfers data
// - read data captured as data strobe rises; responder then releases
// - write data already valid on bus when data strobe falls
// - write data held until after the data strobe rises
// - direction high for read, low for write
// - direction set as address strobe falls, held to transaction end
// - size high for byte, low for word
// - size set as address strobe falls, valid whole transaction
// - byte addresses; word memory accesses force address bit 0 to zero
// - memory byte: even address uses high byte, odd the low byte
// - I/O address names a port; size picks byte or word
// - I/O byte: address bit 0 picks the bus half used
// - status separates memory, normal I/O and special I/O transfers
// - status codes: 0,1,2,3 and 8,9,c,d as listed
// - memory request low only during memory transactions
// - wait low at sampling stretches data phase until sampled high
`timescale 1ns/100ps
module mbi_bus_if import mbi_pkg::*; #(
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // request side
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [15:0] req_addr,
   input wire logic [15:0] req_wdata,
   input wire logic req_read,
   input wire logic req_byte,
   input wire logic [3:0] req_status,
   // completion side
   output logic rsp_valid,
   output logic [15:0] rsp_rdata,
   output logic busy,
   // multiplexed bus pins
   input wire logic [15:0] addr_data_bus_in,
   output logic [15:0] addr_data_bus_out,
   output logic addr_data_bus_oe,
   // strobes and qualifiers
   output logic address_strobe_n,
   output logic data_strobe_n,
   output logic read_write,
   output logic byte_word,
   output logic [3:0] transaction_status,
   output logic memory_request_n,
   input wire logic wait_n
);
   ////////////////////////////////////////////////////////////////////////
   // request queue
   logic [REQ_W-1:0] fifo_in;
   logic [REQ_W-1:0] fifo_out;
   logic fifo_valid;
   logic fifo_ready;
   logic wait_ok;

   assign fifo_in = {req_status, req_byte, req_read, req_wdata, req_addr};

   mbi_fifo #(
      .WIDTH(REQ_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .reset_n(reset_n),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data(fifo_in),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_out)
   );

   // wait comes from another chip, so it is filtered before use
   mbi_sync3 #(
      .RST_VAL(RST_WAIT_N)
   ) u_wait_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .pin_in(wait_n),
      .level_out(wait_ok)
   );

   ////////////////////////////////////////////////////////////////////////
   // decode of the request at the head of the queue
   logic [15:0] head_addr;
   logic [15:0] head_wdata;
   logic head_read;
   logic head_byte;
   logic [3:0] head_status;
   logic head_mem;
   logic [15:0] head_addr_out;

   assign head_addr = fifo_out[F_ADDR_LSB +: BUS_W];
   assign head_wdata = fifo_out[F_WDATA_LSB +: BUS_W];
   assign head_read = fifo_out[F_READ_BIT];
   assign head_byte = fifo_out[F_BYTE_BIT];
   assign head_status = fifo_out[F_ST_LSB +: ST_W];
   assign head_mem = head_status[ST_MEM_BIT];
   // word memory accesses are always even
   assign head_addr_out = (head_mem && !head_byte) ?
      {head_addr[15:1], 1'b0} : head_addr;

   ////////////////////////////////////////////////////////////////////////
   // current transaction, held from address strobe fall to the end
   mbi_state_t state_r;
   logic [CNT_W-1:0] cnt_r;
   logic cur_read_r;
   logic cur_byte_r;
   logic cur_odd_r;
   logic [3:0] cur_status_r;
   logic [15:0] cur_wdata_r;
   logic has_data;
   logic cur_mem;
   logic cur_io;
   logic start;
   logic data_done;
   logic [CNT_W-1:0] ds_cyc;

   assign start = (state_r == S_IDLE) && fifo_valid;
   assign fifo_ready = (state_r == S_IDLE);
   assign busy = (state_r != S_IDLE);
   assign cur_mem = cur_status_r[ST_MEM_BIT];
   // internal and refresh cycles carry no data
   assign cur_io = !cur_mem && cur_status_r[ST_IO_BIT];
   assign has_data = cur_mem || cur_io;
   // wait is only looked at once the least strobe width has run out
   assign data_done = (cnt_r == '0) && wait_ok;

   always_comb begin
      if (cur_io) begin
         ds_cyc = CNT_W'(DS_IO_CYC - 1);
      end else if (cur_read_r) begin
         ds_cyc = CNT_W'(DS_READ_CYC - 1);
      end else begin
         ds_cyc = CNT_W'(DS_WRITE_CYC - 1);
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cur_read_r <= RST_DIR;
         cur_byte_r <= RST_SIZE;
         cur_odd_r <= 1'b0;
         cur_status_r <= ST_INTERNAL;
         cur_wdata_r <= RST_WORD;
      end else if (start) begin
         // qualifiers change together with the address strobe fall
         cur_read_r <= head_read;
         cur_byte_r <= head_byte;
         cur_odd_r <= head_addr_out[0];
         cur_status_r <= head_status;
         cur_wdata_r <= head_wdata;
      end else if (state_r == S_IDLE) begin
         cur_status_r <= ST_INTERNAL;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // phase sequencer
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_r <= S_IDLE;
         cnt_r <= '0;
      end else begin
         unique case (state_r)
            S_IDLE: begin
               if (start) begin
                  state_r <= S_ADDR;
                  cnt_r <= CNT_W'(AS_LOW_CYC - 1);
               end
            end
            S_ADDR: begin
               if (cnt_r != '0) begin
                  cnt_r <= cnt_r - 1'b1;
               end else begin
                  // strobe rises before any data phase begins
                  state_r <= S_GAP;
                  cnt_r <= CNT_W'(ADDR_HOLD_CYC - 1);
               end
            end
            S_GAP: begin
               if (cnt_r != '0) begin
                  cnt_r <= cnt_r - 1'b1;
               end else if (!has_data) begin
                  state_r <= S_IDLE;
               end else if (cur_read_r) begin
                  state_r <= S_DATA;
                  cnt_r <= ds_cyc;
               end else begin
                  state_r <= S_WSET;
                  cnt_r <= CNT_W'(WSETUP_CYC - 1);
               end
            end
            S_WSET: begin
               if (cnt_r != '0) begin
                  cnt_r <= cnt_r - 1'b1;
               end else begin
                  state_r <= S_DATA;
                  cnt_r <= ds_cyc;
               end
            end
            S_DATA: begin
               if (cnt_r != '0) begin
                  cnt_r <= cnt_r - 1'b1;
               end else if (data_done) begin
                  state_r <= S_HOLD;
                  cnt_r <= CNT_W'(DS_HOLD_CYC - 1);
               end
            end
            S_HOLD: begin
               if (cnt_r != '0) begin
                  cnt_r <= cnt_r - 1'b1;
               end else begin
                  state_r <= S_IDLE;
               end
            end
            default: begin
               state_r <= S_IDLE;
               cnt_r <= '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address/data bus drive
   logic [15:0] wdata_lanes;

   // a byte goes out on both halves so either lane choice finds it
   assign wdata_lanes = cur_byte_r ?
      {cur_wdata_r[7:0], cur_wdata_r[7:0]} : cur_wdata_r;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         addr_data_bus_out <= RST_WORD;
         addr_data_bus_oe <= 1'b0;
      end else begin
         if (start) begin
            addr_data_bus_out <= head_addr_out;
            addr_data_bus_oe <= 1'b1;
         end else if (state_r == S_GAP && cnt_r == '0) begin
            if (has_data && !cur_read_r) begin
               addr_data_bus_out <= wdata_lanes;
               addr_data_bus_oe <= 1'b1;
            end else begin
               // read or no-data cycle: float so the responder can drive
               addr_data_bus_oe <= 1'b0;
            end
         end else if (state_r == S_HOLD && cnt_r == '0) begin
            // write data outlives the strobe rise by the hold phase
            addr_data_bus_oe <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // strobes, decoded straight from sequencer flops
   assign address_strobe_n = (state_r == S_ADDR) ? 1'b0 : RST_STROBE_N;
   assign data_strobe_n = (state_r == S_DATA) ? 1'b0 : RST_STROBE_N;
   assign read_write = cur_read_r;
   assign byte_word = cur_byte_r;
   assign transaction_status = cur_status_r;
   assign memory_request_n = !(busy && cur_mem);

   ////////////////////////////////////////////////////////////////////////
   // read capture and completion
   logic [15:0] rdata_pick;

   // even byte address lives in the upper half of the bus
   assign rdata_pick = !cur_byte_r ? addr_data_bus_in :
      (cur_odd_r ? {8'h00, addr_data_bus_in[7:0]} :
       {8'h00, addr_data_bus_in[15:8]});

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rsp_rdata <= RST_WORD;
      end else if (state_r == S_DATA && data_done && cur_read_r) begin
         // taken on the edge that raises the data strobe
         rsp_rdata <= rdata_pick;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= (state_r == S_HOLD && cnt_r == '0) ||
            (state_r == S_GAP && cnt_r == '0 && !has_data);
      end
   end
endmodule // mbi_bus_if

// ==== logic/mbi_fifo.sv ====
// request fifo with valid and ready on both sides
`timescale 1ns/100ps
module mbi_fifo import mbi_pkg::*; #(
   parameter int WIDTH = REQ_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   assign in_ready = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr_r];

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule // mbi_fifo

// ==== logic/mbi_sync3.sv ====
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/100ps
module mbi_sync3 import mbi_pkg::*; #(
   parameter logic RST_VAL = 1'b1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // pin and filtered level
   input wire logic pin_in,
   output logic level_out
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         level_out <= RST_VAL;
      end else if (s2_r == s3_r) begin
         level_out <= s3_r;
      end
   end
endmodule // mbi_sync3

// ==== shared/mbi_pkg.sv ====
// shared constants for the multiplexed bus interface
package mbi_pkg;
   // bus and request widths
   localparam int BUS_W = 16;
   localparam int ST_W = 4;
   localparam int CNT_W = 4;
   localparam int REQ_W = BUS_W + BUS_W + 1 + 1 + ST_W;
   localparam int FIFO_DEPTH = 16;
   // request word field positions
   localparam int F_ADDR_LSB = 0;
   localparam int F_WDATA_LSB = 16;
   localparam int F_READ_BIT = 32;
   localparam int F_BYTE_BIT = 33;
   localparam int F_ST_LSB = 34;
   // transaction status codes, bit 3 first
   localparam logic [3:0] ST_INTERNAL = 4'h0;
   localparam logic [3:0] ST_REFRESH = 4'h1;
   localparam logic [3:0] ST_IO_NORMAL = 4'h2;
   localparam logic [3:0] ST_IO_SPECIAL = 4'h3;
   localparam logic [3:0] ST_MEM_OPERAND = 4'h8;
   localparam int ST_MEM_BIT = 3;
   localparam int ST_IO_BIT = 1;
   // idle levels of the bus outputs and the wait input
   localparam logic RST_STROBE_N = 1'b1;
   localparam logic RST_DIR = 1'b1;
   localparam logic RST_SIZE = 1'b0;
   localparam logic RST_WAIT_N = 1'b1;
   localparam logic [15:0] RST_WORD = 16'h0000;
   // clock and phase timing
   localparam int CLK_NS = 100;
   localparam int AS_LOW_NS = 80;
   localparam int ADDR_HOLD_NS = 60;
   localparam int WDATA_SETUP_NS = 55;
   localparam int DS_READ_NS = 275;
   localparam int DS_WRITE_NS = 160;
   localparam int DS_IO_NS = 400;
   localparam int DS_HOLD_NS = 80;
   // least times round up to whole clock cycles
   localparam int AS_LOW_CYC = (AS_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int WSETUP_CYC = (WDATA_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int DS_READ_CYC = (DS_READ_NS + CLK_NS - 1) / CLK_NS;
   localparam int DS_WRITE_CYC = (DS_WRITE_NS + CLK_NS - 1) / CLK_NS;
   localparam int DS_IO_CYC = (DS_IO_NS + CLK_NS - 1) / CLK_NS;
   localparam int DS_HOLD_CYC = (DS_HOLD_NS + CLK_NS - 1) / CLK_NS;
   // bus sequencer states
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ADDR = 3'b001,
      S_GAP = 3'b010,
      S_WSET = 3'b011,
      S_DATA = 3'b100,
      S_HOLD = 3'b101
   } mbi_state_t;
endpackage

// ==== verif/mbi_bus_monitor.sv ====
// concurrent checks on the bus sequencer ports
`timescale 1ns/100ps
module mbi_bus_monitor import mbi_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // completion side
   input wire logic rsp_valid,
   input wire logic busy,
   // bus pins
   input wire logic [15:0] addr_data_bus_out,
   input wire logic addr_data_bus_oe,
   input wire logic address_strobe_n,
   input wire logic data_strobe_n,
   input wire logic read_write,
   input wire logic byte_word,
   input wire logic [3:0] transaction_status,
   input wire logic memory_request_n,
   input wire logic wait_n
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////
   a_addr_phase: assert property ($fell(address_strobe_n) |->
      addr_data_bus_oe ##1 (address_strobe_n && addr_data_bus_oe
      && $stable(addr_data_bus_out))) else $error("address phase wrong");
   a_phase_order: assert property ($fell(data_strobe_n) |->
      address_strobe_n && $past(address_strobe_n))
      else $error("data strobe overlaps address strobe");
   a_read_release: assert property (!data_strobe_n && read_write |->
      !addr_data_bus_oe) else $error("bus driven during read");
   a_wdata_setup: assert property ($fell(data_strobe_n) && !read_write |->
      addr_data_bus_oe && $stable(addr_data_bus_out))
      else $error("write data not set up");
   a_wdata_hold: assert property ($rose(data_strobe_n) && !read_write |->
      addr_data_bus_oe && $stable(addr_data_bus_out))
      else $error("write data dropped early");
   a_qual_stable: assert property (busy && $past(busy) |->
      $stable({read_write, byte_word, transaction_status}))
      else $error("qualifier changed mid transaction");
   a_status_legal: assert property (!address_strobe_n |->
      transaction_status inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hc,
      4'hd}) else $error("illegal status code");
   a_memory_request_n_match: assert property (!address_strobe_n |->
      memory_request_n == !transaction_status[3])
      else $error("memory request wrong");
   a_memory_request_n_idle: assert property (!busy |-> memory_request_n)
      else $error("memory request while idle");
   a_word_even: assert property (!address_strobe_n && !byte_word
      && transaction_status[3] |-> !addr_data_bus_out[0])
      else $error("odd word address");
   a_read_width: assert property ($fell(data_strobe_n) && read_write
      && transaction_status[3] |-> !data_strobe_n [*3])
      else $error("read strobe too short");
   a_io_width: assert property ($fell(data_strobe_n)
      && !transaction_status[3] |-> !data_strobe_n [*4])
      else $error("io strobe too short");
   a_wait_stretch: assert property ((!wait_n) [*6] ##0 !data_strobe_n
      |=> !data_strobe_n) else $error("wait ignored");
   a_rsp_after: assert property ($rose(data_strobe_n) |=> rsp_valid)
      else $error("no completion after data strobe");
   c_read: cover property ($fell(data_strobe_n) && read_write);
   c_write: cover property ($fell(data_strobe_n) && !read_write);
   c_io: cover property ($fell(data_strobe_n) && !transaction_status[3]);
   c_wait: cover property ((!wait_n) [*6] ##0 !data_strobe_n);
endmodule // mbi_bus_monitor
bind mbi_bus_if mbi_bus_monitor u_mon (.mclk(mclk), .reset_n(reset_n),
   .rsp_valid(rsp_valid), .busy(busy), .addr_data_bus_out(addr_data_bus_out),
   .addr_data_bus_oe(addr_data_bus_oe), .address_strobe_n(address_strobe_n),
   .data_strobe_n(data_strobe_n), .read_write(read_write),
   .byte_word(byte_word), .transaction_status(transaction_status),
   .memory_request_n(memory_request_n), .wait_n(wait_n));

// ==== verif/mbi_mem_model.sv ====
// memory and port responder on the far side of the bus
`timescale 1ns/100ps
module mbi_mem_model import mbi_pkg::*; (
   // clock
   input wire logic mclk,
   // bus from device
   input wire logic [15:0] bus_out,
   input wire logic as_n,
   input wire logic ds_n,
   input wire logic rw,
   input wire logic bw,
   input wire logic [3:0] st,
   input wire logic slow,
   // responder drive
   output logic [15:0] bus_drv,
   output logic wait_n
);
   logic [15:0] mem [0:255];
   logic [15:0] addr_r = 16'h0000;
   logic [2:0] wcnt_r = 3'h0;
   logic ds_r = 1'b1;
   logic [7:0] idx;
   initial for (int i = 0; i < 256; i++) mem[i] = 16'h0123 * 16'(i);
   // port space sits above memory space
   assign idx = {~st[3], addr_r[7:1]};
   // slow mode pulls wait low from the address strobe itself, so the
   // three-stage filter in the device sees it before the data phase ends
   assign wait_n = (wcnt_r == 3'h0) && !(slow && !as_n);
   // plain always: mem and bus_drv also get start values from initial blocks
   always @(posedge mclk) begin
      ds_r <= ds_n;
      if (!as_n) addr_r <= bus_out;
      if (!as_n && slow) wcnt_r <= 3'h7;
      else if (wcnt_r != 3'h0) wcnt_r <= wcnt_r - 3'h1;
      // released lines toggle so a stale value never reads as good
      if (!ds_n && rw) bus_drv <= mem[idx];
      else bus_drv <= ~bus_drv;
      if (ds_n && !ds_r && !rw) begin
         if (!bw) mem[idx] <= bus_out;
         else if (addr_r[0]) mem[idx][7:0] <= bus_out[7:0];
         else mem[idx][15:8] <= bus_out[15:8];
      end
   end
   initial bus_drv = 16'h0000;
endmodule // mbi_mem_model

// ==== verif/tb.sv ====
// self-checking bench for the multiplexed bus sequencer
`timescale 1ns/100ps
module tb import mbi_pkg::*; ;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic req_valid = 1'b0;
   logic req_read = 1'b0;
   logic req_byte = 1'b0;
   logic slow = 1'b0;
   logic [15:0] req_addr = 16'h0000;
   logic [15:0] req_wdata = 16'h0000;
   logic [3:0] req_status = 4'h0;
   logic req_ready, rsp_valid, busy, oe, as_n, ds_n, rw, bw, memory_request_n_n, wait_n;
   logic [15:0] rsp_rdata, bus_out, bus_in, drv;
   logic [3:0] st;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   logic full_seen = 1'b0;
   logic [37:0] qa[$];
   logic [16:0] qr[$];
   logic [37:0] cur;
   logic [16:0] e;
   logic [15:0] ref_mem [0:255];
   logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hc, 4'hd};
   assign bus_in = oe ? bus_out : drv;
   mbi_bus_if #(.DEPTH(16)) DUT (.mclk(mclk), .reset_n(reset_n),
      .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_read(req_read), .req_byte(req_byte),
      .req_status(req_status), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .busy(busy), .addr_data_bus_in(bus_in), .addr_data_bus_out(bus_out),
      .addr_data_bus_oe(oe), .address_strobe_n(as_n), .data_strobe_n(ds_n),
      .read_write(rw), .byte_word(bw), .transaction_status(st),
      .memory_request_n(memory_request_n_n), .wait_n(wait_n));
   mbi_mem_model u_mem (.mclk(mclk), .bus_out(bus_out), .as_n(as_n),
      .ds_n(ds_n), .rw(rw), .bw(bw), .st(st), .slow(slow), .bus_drv(drv),
      .wait_n(wait_n));
   ////////////////////////////////////////////////////////////////////////
   // automatic: the checker block and the main sequence both call it
   task automatic check(input string name, input logic [15:0] seen,
      input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task complete_run;
      $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // reference memory is updated at offer time; service is strictly in order
   task push(input logic [3:0] s, input logic rd, bt, input logic [15:0] a, d);
      logic [7:0] ix;
      logic [15:0] w, ea;
      logic dat;
      ix = {~s[3], a[7:1]};
      dat = s[3] | s[1];
      ea = (s[3] && !bt) ? {a[15:1], 1'b0} : a;
      w = ref_mem[ix];
      qr.push_back({dat && rd,
         bt ? (a[0] ? {8'h00, w[7:0]} : {8'h00, w[15:8]}) : w});
      if (dat && !rd && !bt) ref_mem[ix] = d;
      else if (dat && !rd && a[0]) ref_mem[ix][7:0] = d[7:0];
      else if (dat && !rd) ref_mem[ix][15:8] = d[7:0];
      qa.push_back({s, bt, rd, bt ? {2{d[7:0]}} : d, ea});
      req_valid = 1'b1;
      req_status = s;
      req_read = rd;
      req_byte = bt;
      req_addr = a;
      req_wdata = d;
      while (!req_ready) @(negedge mclk);
      @(negedge mclk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial forever #50 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         complete_run;
      end
   end
   always @(negedge mclk) if (reset_n) begin
      if (!req_ready) full_seen = 1'b1;
      if (!as_n) begin
         cur = qa.pop_front();
         check("address", bus_out, cur[15:0]);
         check("direction", 16'(rw), 16'(cur[32]));
         check("size", 16'(bw), 16'(cur[33]));
         check("status", 16'(st), 16'(cur[37:34]));
         check("mem_req", 16'(memory_request_n_n), 16'(!cur[37]));
      end
      if (!ds_n && !rw) check("wdata", bus_out, cur[31:16]);
      if (rsp_valid) begin
         e = qr.pop_front();
         if (e[16]) check("rdata", rsp_rdata, e[15:0]);
      end
   end
   initial begin
      for (int i = 0; i < 256; i++) ref_mem[i] = 16'h0123 * 16'(i);
      void'($urandom(74));
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      reset_n = 1'b1;
      @(negedge mclk);
      check("idle", 16'({as_n, ds_n, oe, rw, bw, st, memory_request_n_n, rsp_valid,
         req_ready}), 16'h0d05);
      check("idle_bus", bus_out | rsp_rdata, 16'h0000);
      push(4'h8, 1'b0, 1'b0, 16'h0041, 16'hbeef);
      push(4'h9, 1'b0, 1'b1, 16'h0041, 16'h0012);
      push(4'hc, 1'b1, 1'b0, 16'h0040, 16'h0000);
      push(4'hd, 1'b1, 1'b1, 16'h0040, 16'h0000);
      push(4'h2, 1'b0, 1'b1, 16'h0007, 16'h00a5);
      push(4'h3, 1'b1, 1'b1, 16'h0007, 16'h0000);
      push(4'h2, 1'b1, 1'b0, 16'h0007, 16'h0000);
      for (int s = 0; s < 2; s++) begin
         slow = s[0];
         for (int i = 0; i < 24; i++)
            push(codes[i % 8], 1'($urandom), 1'($urandom), 16'($urandom),
               16'($urandom));
      end
      req_valid = 1'b0;
      for (int k = 0; k < 3000 && (qr.size() != 0 || busy); k++)
         @(negedge mclk);
      check("pending", 16'(qr.size()), 16'h0000);
      check("queue_full", 16'(full_seen), 16'h0001);
      complete_run;
   end
endmodule // tb
